/* cps_packet_assembler.sv */
// Turns HDLC packets on grouped time slots into AAL2 CPS-Packets and issues
// byte writes and completion entries for the CPS-Packet circular buffer.
// Assumes line bytes arrive with the base structure index of their stream.
`timescale 1ns/1ps

module cps_packet_assembler #(
    parameter int MAX_PAYLOAD = 64
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Line bytes
    input wire logic i_line_valid,
    input wire logic [7:0] i_line_bits,
    input wire logic [7:0] i_base_slot,
    output logic o_line_ready,
    // Configuration
    input wire logic i_raw_mode,
    input wire logic i_cfg_we,
    input wire logic [1:0] i_cfg_group,
    input wire logic [7:0] i_cfg_slot,
    input wire logic [31:0] i_cfg_data,
    // Buffer writes
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic o_out_desc,
    output logic [7:0] o_out_slot,
    output logic [7:0] o_out_ptr,
    output logic [7:0] o_out_data,
    // Status and monitoring
    output logic o_overflow,
    input wire logic [7:0] i_mon_slot,
    output logic [31:0] o_pkt_count,
    output logic [31:0] o_byte_count
);
    typedef enum logic [2:0] {ST_IDLE, ST_HDR0, ST_HDR1, ST_HDR2, ST_DESC} fin_state_e;

    initial begin
        if (MAX_PAYLOAD < 1 || MAX_PAYLOAD > 64) $error("MAX_PAYLOAD must be 1..64");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Functions

    function automatic logic [4:0] hec5(input logic [18:0] hdr);
        logic [4:0] c;
        logic fb;
        c = 5'h00;
        for (int i = 18; i >= 0; i--) begin
            fb = c[4] ^ hdr[i];
            c = {c[3:0], 1'b0};
            if (fb) c = c ^ cps_asm_pkg::HEC_POLY;
        end
        return c;
    endfunction

    function automatic logic [4:0] pick_uui(input logic raw, input logic [4:0] raw_uui,
                                            input logic [2:0] inc, input logic [3:0] cfg_uui,
                                            input logic [7:0] ctrl, input logic [3:0] cnt);
        logic [3:0] mask;
        mask = 4'hf >> inc;
        if (raw) return raw_uui;
        if (inc == cps_asm_pkg::INC_CTRL) return ctrl[7:3];
        if (inc <= cps_asm_pkg::INC_NONE) return {1'b0, (cfg_uui & ~mask) | (cnt & mask)};
        return {1'b0, cfg_uui};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Per-slot state

    logic st_valid [cps_asm_pkg::NUM_SLOTS];
    logic [3:0] htype [cps_asm_pkg::NUM_SLOTS];
    logic crc_on [cps_asm_pkg::NUM_SLOTS];
    logic [7:0] nch [cps_asm_pkg::NUM_SLOTS];
    logic [7:0] hist [cps_asm_pkg::NUM_SLOTS];
    logic [2:0] ones [cps_asm_pkg::NUM_SLOTS];
    logic [3:0] leading_byte_counter [cps_asm_pkg::NUM_SLOTS];
    logic [7:0] cur_ch [cps_asm_pkg::NUM_SLOTS];
    logic [4:0] raw_uui [cps_asm_pkg::NUM_SLOTS];
    logic open [cps_asm_pkg::NUM_SLOTS];
    logic [7:0] wp [cps_asm_pkg::NUM_SLOTS];
    logic [7:0] sop [cps_asm_pkg::NUM_SLOTS];
    logic [7:0] rp [cps_asm_pkg::NUM_SLOTS];
    logic read_ptr_valid [cps_asm_pkg::NUM_SLOTS];
    logic [7:0] ctrl [cps_asm_pkg::NUM_SLOTS];
    logic [7:0] cid [cps_asm_pkg::NUM_SLOTS];
    logic [3:0] drop [cps_asm_pkg::NUM_SLOTS];
    logic [2:0] inc [cps_asm_pkg::NUM_SLOTS];
    logic [3:0] cfg_uui [cps_asm_pkg::NUM_SLOTS];
    logic [31:0] pkt_cnt [cps_asm_pkg::NUM_SLOTS];
    logic [31:0] byte_cnt [cps_asm_pkg::NUM_SLOTS];

    logic hold_valid;
    logic [7:0] hold_bits;
    logic [7:0] hold_base;
    fin_state_e state;
    logic [7:0] f_slot;
    logic [7:0] f_sop;
    logic [5:0] f_li;
    logic [4:0] f_uui;

    ////////////////////////////////////////////////////////////////////////////
    // Destuffing and byte handling

    logic [7:0] d_hist;
    logic [2:0] d_ones;
    logic [7:0] d_data;
    logic d_dv;
    logic d_flag;
    logic d_abort;

    bit_destuffer destuff (
        .i_bits(hold_bits),
        .i_hist(hist[hold_base]),
        .i_ones(ones[hold_base]),
        .o_hist(d_hist),
        .o_ones(d_ones),
        .o_data(d_data),
        .o_data_valid(d_dv),
        .o_flag(d_flag),
        .o_abort(d_abort)
    );

    entry_if #(.WIDTH(cps_asm_pkg::ENTRY_W)) push_if ();

    logic go;
    logic [7:0] ch;
    logic [1:0] n_addr;
    logic has_ctrl;
    logic subch;
    logic [3:0] k;
    logic [3:0] p;
    logic [7:0] len;
    logic [7:0] next_cur;
    logic [3:0] next_hbc;
    logic [4:0] next_raw_uui;
    logic next_open;
    logic [7:0] next_wp;
    logic [7:0] next_sop;
    logic [7:0] next_ctrl;
    logic [3:0] next_drop;
    logic data_push;
    logic [7:0] data_ptr;
    logic fin;

    assign go = hold_valid && state == ST_IDLE && push_if.ready && !i_cfg_we;
    assign ch = 8'(hold_base + cur_ch[hold_base]);
    assign k = leading_byte_counter[hold_base];

    always_comb begin
        // Header type decode
        n_addr = 2'd0;
        has_ctrl = 1'b0;
        subch = htype[hold_base] > cps_asm_pkg::HT_LAST_PLAIN;
        if (htype[hold_base] != cps_asm_pkg::HT_PLAIN
                && htype[hold_base] <= cps_asm_pkg::HT_LAST_SUBCH) begin
            n_addr = htype[hold_base][0] ? 2'd1 : 2'd2;
            has_ctrl = subch ? htype[hold_base] >= 4'h7 : htype[hold_base] >= 4'h3;
        end
        p = 4'(k - {2'b00, n_addr} - {3'b000, has_ctrl});
        next_cur = cur_ch[hold_base];
        next_hbc = k;
        next_raw_uui = raw_uui[hold_base];
        next_open = open[ch];
        next_wp = wp[ch];
        next_sop = sop[ch];
        next_ctrl = ctrl[ch];
        next_drop = drop[ch];
        data_push = 1'b0;
        data_ptr = wp[ch];
        fin = 1'b0;
        len = 8'h00;
        if (d_dv) begin
            if (k < {2'b00, n_addr}) begin
                // Only the last address byte of a sub-channel header matters
                if (subch && k == 4'({2'b00, n_addr} - 4'd1)) begin
                    next_cur = (nch[hold_base] != 8'h00 && d_data >= nch[hold_base])
                        ? 8'h00 : d_data;
                end
            end else if (has_ctrl && k == {2'b00, n_addr}) begin
                next_ctrl = d_data;
            end else if (i_raw_mode && p < 4'd3) begin
                // Raw header: only UUI is kept
                if (p == 4'd1) next_raw_uui[4:3] = d_data[1:0];
                if (p == 4'd2) next_raw_uui[2:0] = d_data[7:5];
            end else if (st_valid[ch]) begin
                if (!next_open) begin
                    next_sop = wp[ch];
                    data_ptr = 8'(wp[ch] + cps_asm_pkg::CPS_HDR_BYTES);
                    next_open = 1'b1;
                end
                data_push = 1'b1;
                next_wp = 8'(data_ptr + 8'h01);
            end
            if (k != cps_asm_pkg::HBC_SAT) next_hbc = 4'(k + 4'd1);
        end
        if (d_flag || d_abort) begin
            next_hbc = 4'h0;
            next_cur = 8'h00;
            if (next_open) begin
                len = 8'(next_wp - next_sop - cps_asm_pkg::CPS_HDR_BYTES
                    - (crc_on[hold_base] ? cps_asm_pkg::CRC_BYTES : 8'h00));
                if (d_flag && len != 8'h00 && len <= 8'(MAX_PAYLOAD)
                        && drop[ch] == 4'h0) begin
                    fin = 1'b1;
                    next_wp = 8'(next_sop + cps_asm_pkg::CPS_HDR_BYTES + len);
                end else begin
                    next_wp = next_sop;
                    if (d_flag && len != 8'h00 && len <= 8'(MAX_PAYLOAD)
                            && drop[ch] != cps_asm_pkg::DROP_NEVER) begin
                        next_drop = 4'(drop[ch] - 4'h1);
                    end
                end
                next_open = 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Push selection

    logic [7:0] push_ptr;
    logic [7:0] push_data;
    logic push_desc;

    always_comb begin
        push_if.valid = 1'b0;
        push_desc = 1'b0;
        push_ptr = f_sop;
        push_data = 8'h00;
        case (state)
            ST_IDLE: begin
                push_if.valid = go && data_push;
                push_ptr = data_ptr;
                push_data = d_data;
            end
            ST_HDR0: begin
                push_if.valid = 1'b1;
                push_data = cid[f_slot];
            end
            ST_HDR1: begin
                push_if.valid = 1'b1;
                push_ptr = 8'(f_sop + 8'h01);
                push_data = {f_li, f_uui[4:3]};
            end
            ST_HDR2: begin
                push_if.valid = 1'b1;
                push_ptr = 8'(f_sop + 8'h02);
                push_data = {f_uui[2:0], hec5({cid[f_slot], f_li, f_uui})};
            end
            ST_DESC: begin
                push_if.valid = 1'b1;
                push_desc = 1'b1;
                push_data = {2'b00, f_li};
            end
            default: begin
                push_if.valid = 1'b0;
            end
        endcase
        push_if.data = {push_desc, (state == ST_IDLE) ? ch : f_slot, push_ptr, push_data};
    end

    entry_buffer #(.WIDTH(cps_asm_pkg::ENTRY_W)) out_buf (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .in_side(push_if),
        .o_valid(o_out_valid),
        .o_data({o_out_desc, o_out_slot, o_out_ptr, o_out_data}),
        .i_ready(i_out_ready)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Input hold register

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            hold_valid <= 1'b0;
            hold_bits <= 8'h00;
            hold_base <= 8'h00;
            o_line_ready <= 1'b0;
        end else begin
            if (i_line_valid && o_line_ready) begin
                hold_valid <= 1'b1;
                hold_bits <= i_line_bits;
                hold_base <= i_base_slot;
            end else if (go) begin
                hold_valid <= 1'b0;
            end
            // Half rate, but ready stays a plain flop
            o_line_ready <= !(hold_valid && !go) && !(i_line_valid && o_line_ready);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Finalisation sequence

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            state <= ST_IDLE;
            f_slot <= 8'h00;
            f_sop <= 8'h00;
            f_li <= 6'h00;
            f_uui <= 5'h00;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (go && fin) begin
                        state <= ST_HDR0;
                        f_slot <= ch;
                        f_sop <= next_sop;
                        f_li <= 6'(len - 8'h01);
                        f_uui <= pick_uui(i_raw_mode, next_raw_uui, inc[ch], cfg_uui[ch],
                            next_ctrl, pkt_cnt[ch][3:0]);
                    end
                end
                ST_HDR0: if (push_if.ready) state <= ST_HDR1;
                ST_HDR1: if (push_if.ready) state <= ST_HDR2;
                ST_HDR2: if (push_if.ready) state <= ST_DESC;
                ST_DESC: if (push_if.ready) state <= ST_IDLE;
                default: state <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Stream and channel state

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            for (int i = 0; i < cps_asm_pkg::NUM_SLOTS; i++) begin
                st_valid[i] <= 1'b0;
                open[i] <= 1'b0;
                read_ptr_valid[i] <= 1'b0;
                leading_byte_counter[i] <= 4'h0;
                hist[i] <= cps_asm_pkg::HIST_EMPTY;
                ones[i] <= 3'd0;
                cur_ch[i] <= 8'h00;
            end
        end else if (i_cfg_we) begin
            case (i_cfg_group)
                cps_asm_pkg::CFG_STREAM: begin
                    st_valid[i_cfg_slot] <= i_cfg_data[cps_asm_pkg::F_VALID];
                    htype[i_cfg_slot] <= i_cfg_data[cps_asm_pkg::F_HTYPE +: 4];
                    crc_on[i_cfg_slot] <= i_cfg_data[cps_asm_pkg::F_CRC];
                    nch[i_cfg_slot] <= i_cfg_data[cps_asm_pkg::F_NCH +: 8];
                    hist[i_cfg_slot] <= i_cfg_data[cps_asm_pkg::F_HIST +: 8];
                    ones[i_cfg_slot] <= 3'd0;
                    leading_byte_counter[i_cfg_slot] <= 4'h0;
                    cur_ch[i_cfg_slot] <= 8'h00;
                end
                cps_asm_pkg::CFG_READ_PTR: begin
                    rp[i_cfg_slot] <= i_cfg_data[7:0];
                    read_ptr_valid[i_cfg_slot] <= 1'b1;
                end
                cps_asm_pkg::CFG_WRITE_PTR: begin
                    wp[i_cfg_slot] <= i_cfg_data[7:0];
                    sop[i_cfg_slot] <= i_cfg_data[7:0];
                    open[i_cfg_slot] <= 1'b0;
                end
                default: begin
                    drop[i_cfg_slot] <= i_cfg_data[cps_asm_pkg::F_DROP +: 4];
                end
            endcase
        end else if (go) begin
            hist[hold_base] <= d_hist;
            ones[hold_base] <= d_ones;
            leading_byte_counter[hold_base] <= next_hbc;
            cur_ch[hold_base] <= next_cur;
            raw_uui[hold_base] <= next_raw_uui;
            open[ch] <= next_open;
            wp[ch] <= next_wp;
            sop[ch] <= next_sop;
            ctrl[ch] <= next_ctrl;
            drop[ch] <= next_drop;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Final assembly settings and counters

    always_ff @(posedge i_ref_clk) begin
        if (i_cfg_we && i_cfg_group == cps_asm_pkg::CFG_FINAL) begin
            cid[i_cfg_slot] <= i_cfg_data[cps_asm_pkg::F_CID +: 8];
            inc[i_cfg_slot] <= i_cfg_data[cps_asm_pkg::F_INC +: 3];
            cfg_uui[i_cfg_slot] <= i_cfg_data[cps_asm_pkg::F_UUI +: 4];
            pkt_cnt[i_cfg_slot] <= 32'h0000_0000;
            byte_cnt[i_cfg_slot] <= 32'h0000_0000;
        end else if (state == ST_DESC && push_if.ready) begin
            pkt_cnt[f_slot] <= 32'(pkt_cnt[f_slot] + 32'h1);
            byte_cnt[f_slot] <= 32'(byte_cnt[f_slot] + {26'h0, f_li} + 32'h1);
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_overflow <= 1'b0;
            o_pkt_count <= 32'h0000_0000;
            o_byte_count <= 32'h0000_0000;
        end else begin
            // Payload and header bytes both count as writes
            o_overflow <= push_if.valid && push_if.ready && !push_desc
                && read_ptr_valid[push_if.data[cps_asm_pkg::E_SLOT +: 8]]
                && rp[push_if.data[cps_asm_pkg::E_SLOT +: 8]][7:1] == push_ptr[7:1];
            o_pkt_count <= pkt_cnt[i_mon_slot];
            o_byte_count <= byte_cnt[i_mon_slot];
        end
    end
endmodule

/* cps_asm_pkg.sv */
// Constants for the HDLC-to-CPS-Packet assembler: header-type codes, config
// field layouts, buffer entry layout and counter limits.
// Assumes every file refers to these through the package scope.
package cps_asm_pkg;
    localparam int CH_W = 8;
    localparam int NUM_SLOTS = 256;
    // Header types
    localparam logic [3:0] HT_PLAIN = 4'h0;
    localparam logic [3:0] HT_LAST_PLAIN = 4'h4;
    localparam logic [3:0] HT_LAST_SUBCH = 4'h8;
    // Counters and limits
    localparam logic [3:0] HBC_SAT = 4'h8;
    localparam logic [7:0] HIST_EMPTY = 8'h01;
    localparam logic [3:0] DROP_NEVER = 4'hf;
    localparam logic [7:0] CPS_HDR_BYTES = 8'h03;
    localparam logic [7:0] CRC_BYTES = 8'h02;
    localparam logic [4:0] HEC_POLY = 5'h05;
    // Increment codes
    localparam logic [2:0] INC_NONE = 3'h4;
    localparam logic [2:0] INC_CTRL = 3'h5;
    // Configuration groups
    localparam logic [1:0] CFG_STREAM = 2'h0;
    localparam logic [1:0] CFG_READ_PTR = 2'h1;
    localparam logic [1:0] CFG_WRITE_PTR = 2'h2;
    localparam logic [1:0] CFG_FINAL = 2'h3;
    // Stream group fields
    localparam int F_VALID = 0;
    localparam int F_HTYPE = 1;
    localparam int F_CRC = 5;
    localparam int F_NCH = 8;
    localparam int F_HIST = 16;
    // Final assembly group fields
    localparam int F_CID = 0;
    localparam int F_DROP = 8;
    localparam int F_INC = 12;
    localparam int F_UUI = 15;
    // Output entry: {desc, slot, ptr, data}
    localparam int ENTRY_W = 25;
    localparam int E_DATA = 0;
    localparam int E_PTR = 8;
    localparam int E_SLOT = 16;
    localparam int E_DESC = 24;
endpackage

/* entry_if.sv */
// Valid/ready carrier for buffer-write entries between assembler and buffer.
// Assumes source and sink share one clock.
`timescale 1ns/1ps
interface entry_if #(parameter int WIDTH = 25) ();
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport source(output valid, output data, input ready);
    modport sink(input valid, input data, output ready);
endinterface

/* bit_destuffer.sv */
// Combinational zero-bit removal over eight line bits, MSB first.
// Assumes the caller keeps the history byte and ones count per stream.
`timescale 1ns/1ps
module bit_destuffer (
    // Line bits and state in
    input wire logic [7:0] i_bits,
    input wire logic [7:0] i_hist,
    input wire logic [2:0] i_ones,
    // State out
    output logic [7:0] o_hist,
    output logic [2:0] o_ones,
    // Events
    output logic [7:0] o_data,
    output logic o_data_valid,
    output logic o_flag,
    output logic o_abort
);
    always_comb begin
        o_hist = i_hist;
        o_ones = i_ones;
        o_data = 8'h00;
        o_data_valid = 1'b0;
        o_flag = 1'b0;
        o_abort = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            if (o_ones == 3'd5 && !i_bits[i]) begin
                o_ones = 3'd0;
            end else if (o_ones == 3'd6 && !i_bits[i]) begin
                // Flag bits already shifted in are thrown away
                o_flag = 1'b1;
                o_hist = cps_asm_pkg::HIST_EMPTY;
                o_ones = 3'd0;
            end else if (o_ones == 3'd6) begin
                o_abort = 1'b1;
                o_hist = cps_asm_pkg::HIST_EMPTY;
                o_ones = 3'd0;
            end else begin
                o_ones = i_bits[i] ? 3'(o_ones + 3'd1) : 3'd0;
                // Marker bit at the top means seven leftover bits
                if (o_hist[7]) begin
                    o_data = {o_hist[6:0], i_bits[i]};
                    o_data_valid = 1'b1;
                    o_hist = cps_asm_pkg::HIST_EMPTY;
                end else begin
                    o_hist = {o_hist[6:0], i_bits[i]};
                end
            end
        end
    end
endmodule

/* entry_buffer.sv */
// Two-entry buffer with registered outputs; a receiver stall loses nothing.
// Assumes the source waits while ready is low.
`timescale 1ns/1ps
module entry_buffer #(
    parameter int WIDTH = 25
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Fill side
    entry_if.sink in_side,
    // Drain side
    output logic o_valid,
    output logic [WIDTH-1:0] o_data,
    input wire logic i_ready
);
    logic skid_valid;
    logic [WIDTH-1:0] skid_data;
    logic take;

    initial begin
        if (WIDTH < 1) $error("entry_buffer: WIDTH must be positive");
    end

    assign in_side.ready = !skid_valid;
    assign take = in_side.valid && !skid_valid;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_valid <= 1'b0;
            o_data <= '0;
            skid_valid <= 1'b0;
            skid_data <= '0;
        end else if (!o_valid || i_ready) begin
            o_valid <= skid_valid || take;
            o_data <= skid_valid ? skid_data : in_side.data;
            skid_valid <= 1'b0;
        end else if (take) begin
            skid_valid <= 1'b1;
            skid_data <= in_side.data;
        end
    end
endmodule

/* cps_asm_checker.sv */
// Port-level checks on the CPS-Packet assembler.
// Assumes one clock with synchronous reset; bound at the foot.
`timescale 1ns/1ps
module cps_asm_checker #(parameter int MAX_PAYLOAD = 64) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_cfg_we,
    input wire logic [1:0] i_cfg_group,
    input wire logic [7:0] i_mon_slot,
    input wire logic o_out_valid,
    input wire logic i_out_ready,
    input wire logic o_out_desc,
    input wire logic [7:0] o_out_slot,
    input wire logic [7:0] o_out_ptr,
    input wire logic [7:0] o_out_data,
    input wire logic o_overflow,
    input wire logic [31:0] o_pkt_count,
    input wire logic [31:0] o_byte_count
);
    logic rp_seen;
    logic [7:0] ptr1, ptr2, slot1;
    wire take = o_out_valid && i_out_ready;
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) rp_seen <= 1'b0;
        else if (i_cfg_we && i_cfg_group == 2'h1) rp_seen <= 1'b1;
    end
    always_ff @(posedge i_ref_clk) begin
        if (take) {ptr2, ptr1, slot1} <= {ptr1, o_out_ptr, o_out_slot};
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    sequence s_quiet; (!i_cfg_we && $stable(i_mon_slot)) [*3]; endsequence
    sequence s_desc; take && o_out_desc; endsequence
    property p_hold; o_out_valid && !i_out_ready |=> o_out_valid && $stable(
        {o_out_desc, o_out_slot, o_out_ptr, o_out_data}); endproperty
    a_hold: assert property (p_hold) else $error("entry moved while stalled");
    property p_hdr_ptr; s_desc |-> ptr1 == o_out_ptr + 8'h02 && ptr2 == o_out_ptr + 8'h01;
    endproperty
    a_hdr_ptr: assert property (p_hdr_ptr) else $error("header not before desc");
    property p_hdr_slot; s_desc |-> slot1 == o_out_slot; endproperty
    a_hdr_slot: assert property (p_hdr_slot) else $error("header slot differs");
    property p_len_hi; s_desc |-> o_out_data[7:6] == 2'h0; endproperty
    a_len_hi: assert property (p_len_hi) else $error("length upper bits set");
    property p_len_max; s_desc |-> o_out_data < MAX_PAYLOAD; endproperty
    a_len_max: assert property (p_len_max) else $error("length above payload limit");
    property p_ovf_rp; o_overflow |-> rp_seen; endproperty
    a_ovf_rp: assert property (p_ovf_rp) else $error("overflow without read pointer");
    property p_pkt_step; s_quiet |-> o_pkt_count == $past(o_pkt_count) ||
        o_pkt_count == $past(o_pkt_count) + 32'h1; endproperty
    a_pkt_step: assert property (p_pkt_step) else $error("packet count jumped");
    property p_byte_step; s_quiet |-> o_byte_count - $past(o_byte_count) <= MAX_PAYLOAD;
    endproperty
    a_byte_step: assert property (p_byte_step) else $error("byte count jumped");
endmodule
bind cps_packet_assembler cps_asm_checker #(.MAX_PAYLOAD(MAX_PAYLOAD)) u_chk (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_cfg_we(i_cfg_we), .i_cfg_group(i_cfg_group),
    .i_mon_slot(i_mon_slot), .o_out_valid(o_out_valid), .i_out_ready(i_out_ready),
    .o_out_desc(o_out_desc), .o_out_slot(o_out_slot), .o_out_ptr(o_out_ptr),
    .o_out_data(o_out_data), .o_overflow(o_overflow), .o_pkt_count(o_pkt_count),
    .o_byte_count(o_byte_count));

/* hdlc_line_source.sv */
// Line-side byte source for the assembler.
// Assumes the caller sends flags byte-aligned.
`timescale 1ns/1ps
module hdlc_line_source (
    input wire logic i_ref_clk,
    input wire logic i_ready,
    output logic o_valid,
    output logic [7:0] o_bits,
    output logic o_stuck
);
    initial begin
        o_valid = 1'b0;
        o_bits = 8'h55;
        o_stuck = 1'b0;
    end
    // Byte held until ready is sampled high
    task automatic send(input logic [7:0] b);
        int k;
        o_valid <= 1'b1;
        o_bits <= b;
        k = 0;
        @(posedge i_ref_clk);
        while (i_ready !== 1'b1 && k < 200) begin
            @(posedge i_ref_clk);
            k++;
        end
        if (k == 200) o_stuck <= 1'b1;
    endtask
    // Released line shows the inverse, never a stale byte
    task automatic idle();
        o_valid <= 1'b0;
        o_bits <= ~o_bits;
    endtask
endmodule

/* tb_cps_packet_assembler.sv */
// Bench for the assembler: two packets through a stalling receiver.
// Assumes the line source and checker files compile first.
`timescale 1ns/1ps
module tb_cps_packet_assembler;
    logic i_ref_clk = 1'b0, i_rst = 1'b1, i_cfg_we = 1'b0, i_out_ready = 1'b0;
    logic [1:0] i_cfg_group = 2'h0;
    logic [31:0] i_cfg_data = 32'h0, pkt_count, byte_count;
    logic line_valid, line_ready, out_valid, out_desc, overflow, stuck, ovf_seen = 1'b0;
    logic [7:0] line_bits, out_slot, out_ptr, out_data;
    logic [7:0] slot_sel = 8'h00;
    logic [24:0] q[$];
    int err_count = 0, n_checks = 0, cyc = 0;
    always #12.5 i_ref_clk = ~i_ref_clk;
    // Receiver takes one cycle in four so the buffer fills
    always @(posedge i_ref_clk) begin
        cyc <= cyc + 1;
        i_out_ready <= (cyc % 4 == 3);
        if (out_valid && i_out_ready) q.push_back({out_desc, out_slot, out_ptr, out_data});
        if (overflow === 1'b1) ovf_seen <= 1'b1;
    end
    hdlc_line_source u_src (.i_ref_clk(i_ref_clk), .i_ready(line_ready),
        .o_valid(line_valid), .o_bits(line_bits), .o_stuck(stuck));
    cps_packet_assembler #(.MAX_PAYLOAD(64)) DUT (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
        .i_line_valid(line_valid), .i_line_bits(line_bits), .i_base_slot(slot_sel),
        .o_line_ready(line_ready), .i_raw_mode(1'b0), .i_cfg_we(i_cfg_we),
        .i_cfg_group(i_cfg_group), .i_cfg_slot(slot_sel), .i_cfg_data(i_cfg_data),
        .o_out_valid(out_valid), .i_out_ready(i_out_ready), .o_out_desc(out_desc),
        .o_out_slot(out_slot), .o_out_ptr(out_ptr), .o_out_data(out_data),
        .o_overflow(overflow), .i_mon_slot(slot_sel), .o_pkt_count(pkt_count),
        .o_byte_count(byte_count));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("checks=%0d errors=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Strobe stays up across back-to-back writes
    task automatic cfg(input logic [1:0] g, input logic [31:0] d);
        i_cfg_we <= 1'b1;
        i_cfg_group <= g;
        i_cfg_data <= d;
        @(posedge i_ref_clk);
    endtask
    function automatic logic [4:0] hec(input logic [18:0] v);
        logic [4:0] c = 5'h00;
        for (int i = 18; i >= 0; i--) c = {c[3:0], 1'b0} ^ ((c[4] ^ v[i]) ? 5'h05 : 5'h00);
        return c;
    endfunction
    task automatic frame(input logic [7:0] a, input logic [7:0] b, input logic [7:0] cid);
        logic [4:0] uui = 5'h03;
        u_src.send(8'h7e);
        u_src.send(a);
        u_src.send(b);
        u_src.send(8'h7e);
        u_src.idle();
        for (int k = 0; k < 400 && q.size() < 6; k++) @(posedge i_ref_clk);
        check(stuck, 32'h0);
        check(q.size(), 32'h6);
        if (q.size() < 6) test_done();
        check(q[0], {1'b0, slot_sel, 8'h03, a});
        check(q[1], {1'b0, slot_sel, 8'h04, b});
        check(q[2], {1'b0, slot_sel, 8'h00, cid});
        check(q[3], {1'b0, slot_sel, 8'h01, 6'h01, uui[4:3]});
        check(q[4], {1'b0, slot_sel, 8'h02, uui[2:0], hec({cid, 6'h01, uui})});
        check(q[5], {1'b1, slot_sel, 8'h00, 8'h01});
        q.delete();
        repeat (3) @(posedge i_ref_clk);
    endtask
    task automatic test_basic();
        cfg(2'h0, 32'h00010101);
        cfg(2'h1, 32'h00000080);
        cfg(2'h2, 32'h00000000);
        cfg(2'h3, 32'h0001c02a);
        i_cfg_we <= 1'b0;
        @(posedge i_ref_clk);
        frame(8'h11, 8'h22, 8'h2a);
        check(ovf_seen, 32'h0);
        check(pkt_count, 32'h1);
        check(byte_count, 32'h2);
        $display("test_basic done");
    endtask
    // Read pointer on word 2 sits under the second payload byte
    task automatic test_overflow();
        slot_sel <= 8'h05;
        cfg(2'h0, 32'h00010101);
        cfg(2'h1, 32'h00000004);
        cfg(2'h2, 32'h00000000);
        cfg(2'h3, 32'h0001c02a);
        i_cfg_we <= 1'b0;
        @(posedge i_ref_clk);
        frame(8'h33, 8'h44, 8'h2a);
        check(ovf_seen, 32'h1);
        check(pkt_count, 32'h1);
        check(byte_count, 32'h2);
        $display("test_overflow done");
    endtask
    initial begin
        repeat (2) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        repeat (2) @(posedge i_ref_clk);
        test_basic();
        test_overflow();
        test_done();
    end
endmodule
